// ---- design/sac_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Control write aborts and restarts conversion
// - Flag set at end when interrupts off
// - Flag reads zero when interrupts on
// - Interrupt raised at end when enabled
// - Interrupt cleared by data read or control write
// - Reset clears flag, enable, repeat
// - Repeat bit gives continuous conversion
// - Codes zero to nine select pins
// - Codes 1D/1E select high/low reference
// - Reserved codes give undefined result
// - All-ones select powers converter off
// - First conversion after power-off unreliable
// - Interrupt keeps working in wait mode
// - Ten analog inputs shared with pins
// - Conversion ends on the sixteenth converter clock tick
// - High byte read freezes low byte, except in 8-bit truncation mode
// - Two-bit justification selects result format
// - Prescaler divides input clock
module sac_top (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Analog core and pins
    input wire logic crystal_clock_in,
    input wire logic [9:0] core_result_in,
    output logic [4:0] input_select_out,
    output logic converter_power_out,
    output logic conversion_active_out,
    output logic [9:0] pin_override_out,
    output logic done_irq_out
);
    sac_if conv_if ();

    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_held_reg, w_held_reg, w_strb_reg;
    logic [7:0] aw_addr_reg, w_data_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic flag_reg, ie_reg, repeat_reg, irq_reg, settle_reg;
    logic [4:0] sel_reg;
    logic [7:0] cfg_reg;
    sac_pkg::sac_state_t state_reg;
    logic [4:0] cnt_reg;
    logic restart_reg, store_reg, done_reg, active_reg;
    logic [9:0] raw_reg;
    logic [9:0] pin_reg;
    logic power_reg;
    logic do_write, wr_scsr, wr_cfg, ar_hs, rd_high, rd_low, data_read, conv_end;
    logic [7:0] scsr_view;

    // Bus handshakes and decode
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_scsr = do_write && w_strb_reg && aw_addr_reg == sac_pkg::OFF_SCSR;
    assign wr_cfg = do_write && w_strb_reg && aw_addr_reg == sac_pkg::OFF_CLK_CFG;
    assign ar_hs = s_axi_arvalid_in && arready_reg;
    assign rd_high = ar_hs && s_axi_araddr_in == sac_pkg::OFF_RES_HIGH;
    assign rd_low = ar_hs && s_axi_araddr_in == sac_pkg::OFF_RES_LOW;
    assign data_read = rd_high || rd_low;
    assign conv_end = state_reg == sac_pkg::ST_CONVERT && conv_if.tick
        && cnt_reg == sac_pkg::CONV_TICKS - 5'h01;
    assign scsr_view = {flag_reg && !ie_reg, ie_reg, repeat_reg, sel_reg};

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            awready_reg <= 1'b1;
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid_in && awready_reg) begin
            awready_reg <= 1'b0;
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_in;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end else if (bvalid_reg && s_axi_bready_in) begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            wready_reg <= 1'b1;
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
        end else if (s_axi_wvalid_in && wready_reg) begin
            wready_reg <= 1'b0;
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_in[7:0];
            w_strb_reg <= s_axi_wstrb_in[0];
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end else if (bvalid_reg && s_axi_bready_in) begin
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= sac_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= sac_pkg::addr_mapped(aw_addr_reg) ? sac_pkg::RESP_OKAY
                : sac_pkg::RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= sac_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= sac_pkg::addr_mapped(s_axi_araddr_in) ? sac_pkg::RESP_OKAY
                : sac_pkg::RESP_SLVERR;
            unique case (s_axi_araddr_in)
                sac_pkg::OFF_SCSR: rdata_reg <= {24'h00_0000, scsr_view};
                sac_pkg::OFF_RES_HIGH: rdata_reg <= {24'h00_0000, conv_if.high_byte};
                sac_pkg::OFF_RES_LOW: rdata_reg <= {24'h00_0000, conv_if.low_byte};
                sac_pkg::OFF_CLK_CFG: rdata_reg <= {24'h00_0000, cfg_reg[7:1], settle_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else if (rvalid_reg && s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ie_reg <= 1'b0;
            repeat_reg <= 1'b0;
            sel_reg <= sac_pkg::SEL_RESET;
        end else if (wr_scsr) begin
            ie_reg <= w_data_reg[sac_pkg::IE_POS];
            repeat_reg <= w_data_reg[sac_pkg::REPEAT_POS];
            sel_reg <= w_data_reg[4:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cfg_reg <= sac_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg_reg <= {w_data_reg[7:1], 1'b0};
        end
    end

    // Abort and restart on control write
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_reg <= sac_pkg::ST_OFF;
            active_reg <= 1'b0;
            cnt_reg <= 5'h00;
        end else if (wr_scsr) begin
            cnt_reg <= 5'h00;
            active_reg <= w_data_reg[4:0] != sac_pkg::SEL_POWER_OFF;
            state_reg <= (w_data_reg[4:0] == sac_pkg::SEL_POWER_OFF) ? sac_pkg::ST_OFF
                : sac_pkg::ST_CONVERT;
        end else begin
            unique case (state_reg)
                sac_pkg::ST_OFF, sac_pkg::ST_IDLE: cnt_reg <= 5'h00;
                sac_pkg::ST_CONVERT: begin
                    if (conv_end) begin
                        cnt_reg <= 5'h00;
                        state_reg <= repeat_reg ? sac_pkg::ST_CONVERT : sac_pkg::ST_IDLE;
                        active_reg <= repeat_reg;
                    end else if (conv_if.tick) begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            settle_reg <= 1'b1;
        end else if (state_reg == sac_pkg::ST_OFF) begin
            settle_reg <= 1'b1;
        end else if (done_reg) begin
            settle_reg <= 1'b0;
        end
    end

    // Store result, then flag a cycle later
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            restart_reg <= 1'b0;
            store_reg <= 1'b0;
            done_reg <= 1'b0;
            raw_reg <= 10'h000;
        end else begin
            restart_reg <= wr_scsr;
            store_reg <= conv_end && !wr_scsr;
            done_reg <= store_reg && !wr_scsr;
            if (conv_end) begin
                // Reserved codes sample whatever the core gives
                raw_reg <= core_result_in;
            end
        end
    end

    // Completion flag, set wins over read
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            flag_reg <= 1'b0;
        end else if (done_reg && !ie_reg) begin
            flag_reg <= 1'b1;
        end else if (data_read) begin
            flag_reg <= 1'b0;
        end
    end

    // Interrupt request, usable to leave wait
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            irq_reg <= 1'b0;
        end else if (done_reg && ie_reg) begin
            irq_reg <= 1'b1;
        end else if (data_read || wr_scsr) begin
            // Cleared by data read or control write
            irq_reg <= 1'b0;
        end
    end

    // Pin takeover for ten shared inputs
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pin_reg <= 10'h000;
            power_reg <= 1'b0;
        end else begin
            // Codes zero to nine pick a pin
            pin_reg <= sac_pkg::sel_is_pin(sel_reg) ? 10'(10'h001 << sel_reg) : 10'h000;
            // Reference codes pass to the core select
            power_reg <= sel_reg != sac_pkg::SEL_POWER_OFF;
        end
    end

    assign conv_if.restart = restart_reg;
    assign conv_if.div_sel = cfg_reg[sac_pkg::DIV_POS +: 3];
    assign conv_if.src_sel = cfg_reg[sac_pkg::SRC_POS];
    assign conv_if.store = store_reg;
    assign conv_if.raw = raw_reg;
    assign conv_if.mode = cfg_reg[sac_pkg::MODE_POS +: 2];
    assign conv_if.rd_high = rd_high;
    assign conv_if.rd_low = rd_low;

    sac_prescale u_prescale (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .crystal_clock_in(crystal_clock_in),
        .conv_if(conv_if)
    );
    sac_result u_result (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .res_if(conv_if)
    );

    assign s_axi_awready_out = awready_reg;
    assign s_axi_wready_out = wready_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_arready_out = arready_reg;
    assign s_axi_rdata_out = rdata_reg;
    assign s_axi_rresp_out = rresp_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign input_select_out = sel_reg;
    assign converter_power_out = power_reg;
    assign conversion_active_out = active_reg;
    assign pin_override_out = pin_reg;
    assign done_irq_out = irq_reg;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    chk_write_restart: assert property (wr_scsr |=> cnt_reg == 5'h00 && restart_reg)
        else $error("control write did not restart conversion");
    chk_flag_set: assert property (done_reg && !ie_reg |=> flag_reg)
        else $error("flag not set at conversion end");
    chk_flag_masked: assert property (ar_hs && ie_reg
        && s_axi_araddr_in == sac_pkg::OFF_SCSR |=> !s_axi_rdata_out[sac_pkg::FLAG_POS])
        else $error("flag visible while interrupts enabled");
    chk_irq_raise: assert property (done_reg && ie_reg |=> done_irq_out)
        else $error("interrupt not raised at conversion end");
    chk_irq_clear: assert property ((data_read || wr_scsr) && !done_reg |=> !done_irq_out)
        else $error("interrupt not cleared");
    chk_reset_values: assert property ($rose(rst_n_in) |-> !flag_reg && !ie_reg && !repeat_reg)
        else $error("reset left control bits set");
    chk_repeat_next: assert property (conv_end && repeat_reg && !wr_scsr |=> conversion_active_out && cnt_reg == 5'h00)
        else $error("continuous mode did not restart");
    chk_power_off: assert property (sel_reg == sac_pkg::SEL_POWER_OFF |-> state_reg == sac_pkg::ST_OFF)
        else $error("converter running while powered off");
    chk_store_order: assert property (conv_end && !wr_scsr ##1 !wr_scsr |=> done_reg)
        else $error("flag step did not follow store");
    cov_single: cover property (conv_end && !repeat_reg);
    cov_repeat: cover property (conv_end && repeat_reg);
    cov_irq: cover property ($rose(done_irq_out));
endmodule
`default_nettype wire

// ---- design/sac_pkg.sv ----
package sac_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_SCSR = 8'h00;
    localparam logic [7:0] OFF_RES_HIGH = 8'h04;
    localparam logic [7:0] OFF_RES_LOW = 8'h08;
    localparam logic [7:0] OFF_CLK_CFG = 8'h0C;

    // Status/control fields
    localparam int FLAG_POS = 7;
    localparam int IE_POS = 6;
    localparam int REPEAT_POS = 5;

    // Clock configuration fields
    localparam int DIV_POS = 5;
    localparam int SRC_POS = 4;
    localparam int MODE_POS = 2;
    localparam int SETTLE_POS = 0;

    // Reset values
    localparam logic [4:0] SEL_RESET = 5'h1F;
    localparam logic [7:0] CFG_RESET = 8'h04;

    // Input select codes
    localparam logic [4:0] SEL_LAST_PIN = 5'h09;
    localparam logic [4:0] SEL_HIGH_REF = 5'h1D;
    localparam logic [4:0] SEL_LOW_REF = 5'h1E;
    localparam logic [4:0] SEL_POWER_OFF = 5'h1F;
    localparam int PIN_COUNT = 10;

    // Justification codes
    localparam logic [1:0] JUST_TRUNC8 = 2'h0;
    localparam logic [1:0] JUST_RIGHT = 2'h1;
    localparam logic [1:0] JUST_LEFT = 2'h2;
    localparam logic [1:0] JUST_LEFT_SIGN = 2'h3;

    // Converter clock ticks per conversion
    localparam logic [4:0] CONV_TICKS = 5'h10;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_CONVERT} sac_state_t;

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == OFF_SCSR) || (a == OFF_RES_HIGH) || (a == OFF_RES_LOW) || (a == OFF_CLK_CFG);
    endfunction

    function automatic logic sel_is_pin(input logic [4:0] s);
        return s <= SEL_LAST_PIN;
    endfunction

endpackage

// ---- design/sac_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface sac_if;
    logic tick;
    logic restart;
    logic [2:0] div_sel;
    logic src_sel;
    logic store;
    logic [9:0] raw;
    logic [1:0] mode;
    logic rd_high;
    logic rd_low;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
    modport prescale (input restart, div_sel, src_sel, output tick);
    modport result (input store, raw, mode, rd_high, rd_low, output high_byte, low_byte);
endinterface
`default_nettype wire

// ---- design/sac_prescale.sv ----
`timescale 1ns/100ps
`default_nettype none
module sac_prescale (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Crystal clock pin
    input wire logic crystal_clock_in,
    // Converter clock link
    sac_if.prescale conv_if
);
    logic [2:0] xtal_sync_reg;
    logic xtal_level_reg;
    logic [3:0] div_cnt_reg;
    logic tick_reg;
    logic src_tick;
    logic [3:0] limit;

    // Three-stage crystal clock synchroniser
    always_ff @(posedge clock_in) begin
        xtal_sync_reg <= {xtal_sync_reg[1:0], crystal_clock_in};
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            xtal_level_reg <= 1'b0;
        end else if (xtal_sync_reg[1] == xtal_sync_reg[2]) begin
            xtal_level_reg <= xtal_sync_reg[2];
        end
    end

    assign src_tick = conv_if.src_sel ? 1'b1 :
        (xtal_sync_reg[1] == xtal_sync_reg[2]) && xtal_sync_reg[2] && !xtal_level_reg;
    assign limit = conv_if.div_sel[2] ? 4'hF :
        4'((5'h01 << conv_if.div_sel[1:0]) - 5'h01);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in || conv_if.restart) begin
            div_cnt_reg <= 4'h0;
        end else if (src_tick) begin
            div_cnt_reg <= (div_cnt_reg >= limit) ? 4'h0 : div_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= !conv_if.restart && src_tick && (div_cnt_reg >= limit);
        end
    end

    assign conv_if.tick = tick_reg;
endmodule
`default_nettype wire

// ---- design/sac_result.sv ----
`timescale 1ns/100ps
`default_nettype none
module sac_result (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Result link
    sac_if.result res_if
);
    logic [7:0] high_reg;
    logic [7:0] low_reg;
    logic lock_reg;
    logic [9:0] r;

    assign r = res_if.raw;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            lock_reg <= 1'b0;
        end else if (res_if.rd_low) begin
            lock_reg <= 1'b0;
        end else if (res_if.rd_high && res_if.mode != sac_pkg::JUST_TRUNC8) begin
            lock_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            high_reg <= 8'h00;
            low_reg <= 8'h00;
        end else if (res_if.store && !lock_reg
                && !(res_if.rd_high && res_if.mode != sac_pkg::JUST_TRUNC8)) begin
            unique case (res_if.mode)
                sac_pkg::JUST_TRUNC8: begin
                    high_reg <= 8'h00;
                    low_reg <= r[9:2];
                end
                sac_pkg::JUST_RIGHT: begin
                    high_reg <= {6'h00, r[9:8]};
                    low_reg <= r[7:0];
                end
                sac_pkg::JUST_LEFT: begin
                    high_reg <= r[9:2];
                    low_reg <= {r[1:0], 6'h00};
                end
                sac_pkg::JUST_LEFT_SIGN: begin
                    high_reg <= {~r[9], r[8:2]};
                    low_reg <= {r[1:0], 6'h00};
                end
            endcase
        end
    end

    assign res_if.high_byte = high_reg;
    assign res_if.low_byte = low_reg;
endmodule
`default_nettype wire

// ---- test/sac_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module sac_core_model (
    // Mux select and power
    input wire logic [4:0] sel_in,
    input wire logic power_in,
    input wire logic [9:0] bias_in,
    // Crystal clock and result
    output logic crystal_clock_out,
    output logic [9:0] result_out
);
    logic [9:0] noise;

    initial begin
        crystal_clock_out = 1'b0;
        noise = 10'h155;
        #5;
        forever #100 crystal_clock_out = ~crystal_clock_out;
    end

    always @(posedge crystal_clock_out) begin
        noise <= {noise[8:0], ~noise[9]};
    end

    always_comb begin
        if (!power_in) result_out = noise;
        else if (sel_in == 5'h1D) result_out = 10'h3FF;
        else if (sel_in == 5'h1E) result_out = 10'h000;
        else if (sel_in <= 5'h09) result_out = {sel_in, 5'h0B} ^ bias_in;
        else result_out = noise;
    end
endmodule
`default_nettype wire

// ---- test/sac_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module sac_top_tb;
    logic clock_in, rst_n_in;
    logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdat;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
    logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
    logic s_axi_rvalid_out, s_axi_rready_in, crystal_clock_in, converter_power_out;
    logic conversion_active_out, done_irq_out;
    logic [9:0] core_result_in, pin_override_out, bias, v;
    logic [4:0] input_select_out;
    int errors, cmp_count, waited, k, ds;

    sac_top sac_top_i (.*);
    sac_core_model sac_core_model_i (
        .sel_in(input_select_out),
        .power_in(converter_power_out),
        .bias_in(bias),
        .crystal_clock_out(crystal_clock_in),
        .result_out(core_result_in)
    );

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic fail;
        errors++;
        $display("Error at %0t: wait timed out", $time);
        report_and_stop();
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_end(input string s);
        $display("test %s finished", s);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= {24'h0, d};
        s_axi_wstrb_in <= s;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1 && n < 100);
        rsp = s_axi_bresp_out;
        if (n >= 100) fail();
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1 && n < 100);
        rdat = s_axi_rdata_out;
        rsp = s_axi_rresp_out;
        if (n >= 100) fail();
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rdat, e);
    endtask

    task automatic wflag;
        int n;
        n = 0;
        do begin
            rd(8'h00);
            n++;
        end while (rdat[7] !== 1'b1 && n < 200);
        if (n >= 200) fail();
    endtask

    task automatic wirq;
        waited = 0;
        while (done_irq_out !== 1'b1) begin
            @(posedge clock_in);
            waited++;
            if (waited > 2000) fail();
        end
    endtask

    function automatic logic [9:0] pv(input logic [4:0] n);
        return {n, 5'h0B} ^ bias;
    endfunction

    task automatic res(input logic [1:0] m, input logic [9:0] x);
        logic [15:0] e;
        case (m)
            sac_pkg::JUST_TRUNC8: e = {8'h00, x[9:2]};
            sac_pkg::JUST_RIGHT: e = {6'h00, x};
            sac_pkg::JUST_LEFT: e = {x, 6'h00};
            default: e = {~x[9], x[8:0], 6'h00};
        endcase
        rc(8'h04, e[15:8]);
        rc(8'h08, e[7:0]);
    endtask

    initial begin
        errors = 0;
        cmp_count = 0;
        bias = 10'h000;
        rst_n_in = 1'b0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in} = '0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = '0;
        s_axi_bready_in = 1'b1;
        s_axi_rready_in = 1'b1;
        repeat (6) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        rc(8'h00, 32'h1F);
        rc(8'h0C, 32'h05);
        chk(converter_power_out, 1'b0);
        wr(8'h10, 8'h00, 4'hF);
        chk(rsp, sac_pkg::RESP_SLVERR);
        rc(8'h10, 32'h0);
        chk(rsp, sac_pkg::RESP_SLVERR);
        wr(8'h00, 8'h03, 4'h0);
        rc(8'h00, 32'h1F);
        test_end("reset");
        wr(8'h0C, 8'h14, 4'hF);
        for (k = 0; k < 10; k++) begin
            wr(8'h00, k[7:0], 4'hF);
            if (k == 0) rc(8'h0C, 32'h15);
            wflag();
            chk(pin_override_out, 10'h001 << k);
            chk(input_select_out, k[4:0]);
            chk(conversion_active_out, 1'b0);
            res(sac_pkg::JUST_RIGHT, pv(k[4:0]));
            rc(8'h00, k);
        end
        rc(8'h0C, 32'h14);
        for (k = 0; k < 2; k++) begin
            wr(8'h00, 8'h1D + k[7:0], 4'hF);
            wflag();
            chk(pin_override_out, 10'h000);
            res(sac_pkg::JUST_RIGHT, k ? 10'h000 : 10'h3FF);
        end
        for (k = 0; k < 4; k++) begin
            wr(8'h0C, {4'h1, k[1:0], 2'h0}, 4'hF);
            wr(8'h00, 8'h05, 4'hF);
            wflag();
            res(k[1:0], pv(5'h05));
        end
        test_end("select and format");
        wr(8'h0C, 8'h14, 4'hF);
        wr(8'h00, 8'h02, 4'hF);
        wflag();
        wr(8'h00, 8'h42, 4'hF);
        wirq();
        rc(8'h00, 32'h42);
        chk(done_irq_out, 1'b1);
        rd(8'h08);
        chk(done_irq_out, 1'b0);
        wr(8'h00, 8'h42, 4'hF);
        wirq();
        wr(8'h00, 8'h01, 4'hF);
        @(posedge clock_in);
        chk(done_irq_out, 1'b0);
        repeat (4) @(posedge clock_in);
        wr(8'h00, 8'h04, 4'hF);
        wflag();
        res(sac_pkg::JUST_RIGHT, pv(5'h04));
        test_end("interrupt and abort");
        for (k = 0; k < 6; k++) begin
            wr(8'h0C, {k[2:0], 5'h14}, 4'hF);
            wr(8'h00, 8'h43, 4'hF);
            wirq();
            ds = (k > 3) ? 16 : (1 << k);
            chk(waited >= 15 * ds && waited <= 17 * ds + 4, 1'b1);
            rd(8'h08);
        end
        wr(8'h0C, 8'h04, 4'hF);
        wr(8'h00, 8'h43, 4'hF);
        wirq();
        chk(waited >= 70 && waited <= 100, 1'b1);
        rd(8'h08);
        test_end("timing");
        wr(8'h0C, 8'h14, 4'hF);
        wr(8'h00, 8'h22, 4'hF);
        wflag();
        rd(8'h04);
        v = pv(5'h02);
        chk(rdat, v[9:8]);
        bias <= 10'h0FF;
        repeat (60) @(posedge clock_in);
        chk(conversion_active_out, 1'b1);
        rc(8'h08, v[7:0]);
        repeat (25) @(posedge clock_in);
        res(sac_pkg::JUST_RIGHT, pv(5'h02));
        wr(8'h00, 8'h1F, 4'hF);
        repeat (40) @(posedge clock_in);
        chk(converter_power_out, 1'b0);
        chk(conversion_active_out, 1'b0);
        rc(8'h0C, 32'h15);
        test_end("continuous and power");
        report_and_stop();
    end
endmodule
`default_nettype wire
